// file: include/done_signal_pkg.sv
package done_signal_pkg;
  // operation kinds that end in a completion report
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_ERASE = 2'h1,
    OP_LOAD = 2'h2
  } op_kind_t;

  // configuration defaults
  localparam logic POLARITY_RESET = 1'h1;
  localparam logic OUTPUT_ENABLE_RESET = 1'h1;
  localparam logic AUTO_MODE_RESET = 1'h0;
  // status bit value after reset, before boot copy is done
  localparam logic DONE_BIT_RESET = 1'h0;
endpackage

// file: include/done_signal_if.sv
`timescale 1ns/1ps
interface done_signal_if;
  // completion pin, driven value and enable plus resolved wire level
  logic done_pin_o;
  logic done_pin_oe;
  logic done_pin_level;
  // status bit as seen by the host over the register path
  logic done_status;
  // host side register actions
  logic clear_status;
  logic command_write;
  done_signal_pkg::op_kind_t command_kind;

  // wire level: driven value, else floats (seen as low here)
  assign done_pin_level = done_pin_oe ? done_pin_o : 1'b0;

  modport device_end (
    output done_pin_o,
    output done_pin_oe,
    output done_status,
    input clear_status,
    input command_write,
    input command_kind
  );

  modport host_end (
    input done_pin_level,
    input done_status,
    output clear_status,
    output command_write,
    output command_kind
  );
endinterface

// file: verilog/done_device.sv
`timescale 1ns/1ps
// Function
// [RULE1] idle, default polarity: pin held high
// [RULE2] normal mode: host clears bit before command
// [RULE3] cleared bit drives pin low
// [RULE4] auto mode: device clears bit on command
// [RULE5] operation finished: bit and pin high
// [RULE6] program, erase, load all report completion
// [RULE7] pin driven both levels, not open-drain
// [RULE8] host takes pin rising edge as done
// [RULE9] host may poll bit until high
// [RULE10] polling host should disable pin output
// [RULE11] cold reset: high after copy and reset
// [RULE12] defaults: output enabled, polarity one
// [RULE13] inverted polarity drives inverse of bit
// [RULE14] output disabled: pin floats, bit updates
module done_device (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // link to host
  done_signal_if.device_end link,
  // configuration
  input wire logic polarity_i,
  input wire logic done_pin_output_enable_i,
  input wire logic auto_mode_i,
  // reset pin and boot copy status
  input wire logic hard_reset_input_n_i,
  input wire logic boot_copy_done_i,
  // internal controller
  input wire logic op_finished_i,
  output logic op_start_o,
  output done_signal_pkg::op_kind_t op_kind_o
);
  // status bit
  logic done_bit;
  logic next_done_bit;
  // boot wait
  logic boot_pending;
  logic next_boot_pending;
  // operation in progress
  logic busy;
  logic next_busy;
  done_signal_pkg::op_kind_t next_op_kind;
  // reset pin synchroniser
  logic reset_pin_meta;
  logic next_reset_pin_meta;
  logic reset_pin_sync;
  logic next_reset_pin_sync;

  // boot wait over: copy done and reset pin released
  function automatic logic boot_released(
    input logic pending,
    input logic copy_done,
    input logic pin_released
  );
    boot_released = pending && copy_done && pin_released;
  endfunction

  // command taken: write strobe, idle, boot wait over
  function automatic logic command_taken(
    input logic write,
    input logic is_busy,
    input logic pending
  );
    command_taken = write && !is_busy && !pending;
  endfunction

  // operation over: controller report while busy
  function automatic logic operation_ends(
    input logic is_busy,
    input logic finished
  );
    operation_ends = is_busy && finished;
  endfunction

  // pin level: follows the bit, or its inverse
  function automatic logic pin_drive(
    input logic bit_value,
    input logic polarity
  );
    pin_drive = polarity ? bit_value : ~bit_value;
  endfunction

  // reset pin synchroniser next values
  always_comb
  begin
    next_reset_pin_meta = hard_reset_input_n_i;
    next_reset_pin_sync = reset_pin_meta;
  end

  // two flops before any logic reads the pin
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reset_pin_meta <= 1'b0;
      reset_pin_sync <= 1'b0;
    end
    else
    begin
      reset_pin_meta <= next_reset_pin_meta;
      reset_pin_sync <= next_reset_pin_sync;
    end
  end

  // boot wait ends whichever of copy and pin comes later
  always_comb
  begin
    next_boot_pending = boot_pending;
    if (boot_released(boot_pending, boot_copy_done_i, reset_pin_sync)) // [RULE11]
      next_boot_pending = 1'b0;
  end

  // boot wait register
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      boot_pending <= 1'b1;
    end
    else
    begin
      boot_pending <= next_boot_pending;
    end
  end

  // busy from command taken until the controller reports
  always_comb
  begin
    next_busy = busy;
    if (command_taken(link.command_write, busy, boot_pending))
      next_busy = 1'b1;
    if (operation_ends(busy, op_finished_i))
      next_busy = 1'b0;
  end

  // busy register
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy <= 1'b0;
    end
    else
    begin
      busy <= next_busy;
    end
  end

  // kind of the running operation, kept for the controller
  always_comb
  begin
    next_op_kind = op_kind_o;
    if (command_taken(link.command_write, busy, boot_pending))
      next_op_kind = link.command_kind; // [RULE6]
  end

  // operation kind register
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      op_kind_o <= done_signal_pkg::OP_PROGRAM;
    end
    else
    begin
      op_kind_o <= next_op_kind;
    end
  end

  // status bit: host or auto clear, set on finish
  always_comb
  begin
    next_done_bit = done_bit;
    if (boot_released(boot_pending, boot_copy_done_i, reset_pin_sync))
      next_done_bit = 1'b1; // [RULE11]
    if (!boot_pending && link.clear_status)
      next_done_bit = 1'b0; // [RULE3]
    if (auto_mode_i && command_taken(link.command_write, busy, boot_pending))
      next_done_bit = 1'b0; // [RULE4]
    // finish wins over a same-cycle clear
    if (operation_ends(busy, op_finished_i))
      next_done_bit = 1'b1; // [RULE5]
  end

  // status bit register
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      done_bit <= done_signal_pkg::DONE_BIT_RESET;
    end
    else
    begin
      done_bit <= next_done_bit;
    end
  end

  // start pulse to the internal controller
  assign op_start_o = command_taken(link.command_write, busy, boot_pending);
  // status bit as the host reads it
  assign link.done_status = done_bit; // [RULE9]

  // pin: push-pull at both levels, polarity applied
  assign link.done_pin_o = pin_drive(done_bit, polarity_i); // [RULE1] [RULE13] [RULE12]
  // pin floats while its output is disabled
  assign link.done_pin_oe = done_pin_output_enable_i; // [RULE7] [RULE14]
endmodule

// file: verilog/done_host.sv
`timescale 1ns/1ps
module done_host (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // link to device
  done_signal_if.host_end link,
  // user side
  input wire logic use_pin_i,
  input wire logic auto_mode_i,
  input wire logic cmd_valid_i,
  input wire done_signal_pkg::op_kind_t cmd_kind_i,
  output logic cmd_ready_o,
  output logic cmd_done_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } host_state_t;

  host_state_t state;
  host_state_t next_state;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic next_done;
  logic done_q;

  // two-flop sync of the pin, then edge history
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= link.done_pin_level;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // sequencing
  always_comb
  begin
    next_state = state;
    next_done = 1'b0;
    link.clear_status = 1'b0;
    link.command_write = 1'b0;
    link.command_kind = cmd_kind_i;
    unique case (state)
      ST_IDLE:
      begin
        if (cmd_valid_i && link.done_status)
        begin
          // clear first unless the device does it
          link.clear_status = !auto_mode_i; // [RULE2]
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        link.command_write = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (use_pin_i ? (pin_sync && !pin_prev) : link.done_status) // [RULE8] [RULE9]
        begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      done_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      done_q <= next_done;
    end
  end

  assign cmd_ready_o = (state == ST_IDLE) && link.done_status;
  assign cmd_done_o = done_q;
endmodule

// file: test/done_signal_asserts.sv
`timescale 1ns/1ps
module done_signal_asserts (
  // clock, reset, device settings
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic polarity_i,
  input wire logic done_pin_output_enable_i,
  input wire logic auto_mode_i,
  input wire logic boot_copy_done_i,
  // link signals
  input wire logic done_pin_o,
  input wire logic done_pin_oe,
  input wire logic done_status,
  input wire logic clear_status,
  input wire logic command_write
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // pin versus status bit and enable setting
  property p_pol; done_pin_oe |-> done_pin_o == (done_status == polarity_i); endproperty
  property p_oe; done_pin_oe == done_pin_output_enable_i; endproperty
  property p_low; $fell(done_status) && done_pin_oe && polarity_i |-> $fell(done_pin_o); endproperty
  // status bit sequencing
  property p_clr; clear_status && done_status |=> !done_status; endproperty
  property p_auto; auto_mode_i && command_write |-> ##[1:2] !done_status; endproperty
  property p_order; !auto_mode_i && command_write |-> $past(clear_status); endproperty
  property p_hold; done_status && !clear_status && !command_write && !$past(command_write) |=> done_status; endproperty
  property p_boot; !boot_copy_done_i |-> !done_status; endproperty
  a_pol: assert property (p_pol) else $error("pin level wrong");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_low: assert property (p_low) else $error("pin did not fall");
  a_clr: assert property (p_clr) else $error("clear ignored");
  a_auto: assert property (p_auto) else $error("auto clear missing");
  a_order: assert property (p_order) else $error("command without clear");
  a_hold: assert property (p_hold) else $error("status dropped");
  a_boot: assert property (p_boot) else $error("status before boot");
  // main scenarios
  cover property ($rose(done_status));
  cover property (auto_mode_i && command_write);
  cover property (!done_pin_oe && $rose(done_status));
endmodule

// file: test/tb_command_done_interrupt_signal.sv
`timescale 1ns/1ps
module tb_command_done_interrupt_signal;
  logic core_clk_i = 0;
  logic rstn_i = 0;
  logic pol = 1, oe = 1, auto = 0, boot = 1, fin = 0, use_pin = 1, vld = 0;
  logic start, rdy, done;
  logic hrst_n = 0;
  done_signal_pkg::op_kind_t kind = done_signal_pkg::OP_PROGRAM;
  done_signal_pkg::op_kind_t got_kind;
  // kind, polarity, auto, use pin | expected kind, expected level
  logic [7:0] rows [6] = '{8'h29, 8'h73, 8'h84, 8'hbd, 8'h42, 8'h10};
  int mismatches = 0;
  int n_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  done_signal_if link ();
  done_device done_device_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link), .polarity_i(pol),
    .done_pin_output_enable_i(oe), .auto_mode_i(auto), .hard_reset_input_n_i(hrst_n), .boot_copy_done_i(boot),
    .op_finished_i(fin), .op_start_o(start), .op_kind_o(got_kind));
  done_host done_host_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link), .use_pin_i(use_pin),
    .auto_mode_i(auto), .cmd_valid_i(vld), .cmd_kind_i(kind), .cmd_ready_o(rdy), .cmd_done_o(done));
  done_signal_asserts done_signal_asserts_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .polarity_i(pol),
    .done_pin_output_enable_i(oe), .auto_mode_i(auto), .boot_copy_done_i(boot), .done_pin_o(link.done_pin_o),
    .done_pin_oe(link.done_pin_oe), .done_status(link.done_status), .clear_status(link.clear_status),
    .command_write(link.command_write));
  // controller ends each operation four cycles after start
  always @(posedge core_clk_i)
    if (start)
    begin
      repeat (4) @(posedge core_clk_i);
      #1 fin = 1;
      @(posedge core_clk_i);
      #1 fin = 0;
    end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait on ready or done
  task wait_for(input logic pick);
    int t;
    t = 0;
    while ((pick ? done : rdy) !== 1'b1)
    begin
      @(posedge core_clk_i);
      #1 t++;
      if (t > 300)
      begin
        mismatches++;
        report_and_stop;
      end
    end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    #1 rstn_i = 1;
    hrst_n = 1;
    repeat (6) @(posedge core_clk_i);
    #1 chk({1'b0, link.done_status}, 2'h1);
    // one command per row
    for (int i = 0; i < 6; i++)
    begin
      kind = done_signal_pkg::op_kind_t'(rows[i][7:6]);
      {pol, auto, use_pin} = rows[i][5:3];
      oe = use_pin;
      // let the synchronised pin settle, no false edge from enabling it
      repeat (4) @(posedge core_clk_i);
      #1 vld = 1;
      wait_for(1'b0);
      @(posedge core_clk_i);
      #1 vld = 0;
      wait_for(1'b1);
      chk({1'b0, link.done_status}, 2'h1);
      chk(got_kind, rows[i][2:1]);
      chk({1'b0, link.done_pin_level}, {1'b0, oe & rows[i][0]});
    end
    // inverted polarity with the pin driven
    pol = 0;
    oe = 1;
    @(posedge core_clk_i);
    #1 chk({1'b0, link.done_pin_level}, 2'h0);
    pol = 1;
    @(posedge core_clk_i);
    #1 chk({1'b0, link.done_pin_level}, 2'h1);
    // second reset: boot copy and reset pin released in turn
    rstn_i = 0;
    hrst_n = 0;
    boot = 0;
    @(posedge core_clk_i);
    #1 chk({1'b0, link.done_pin_level}, 2'h0);
    rstn_i = 1;
    repeat (6) @(posedge core_clk_i);
    #1 chk({1'b0, link.done_status}, 2'h0);
    chk({1'b0, rdy}, 2'h0);
    boot = 1;
    repeat (6) @(posedge core_clk_i);
    #1 chk({1'b0, link.done_status}, 2'h0);
    hrst_n = 1;
    repeat (6) @(posedge core_clk_i);
    #1 chk({1'b0, link.done_pin_level}, 2'h1);
    report_and_stop;
  end
endmodule
